// >>> src/branch_skip_pkg.sv
// Shared constants and types for the branch and skip control unit
package branch_skip_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PC_W   = 14;
    localparam int REL_W  = 12;
    localparam int BR_W   = 7;
    localparam int CYC_W  = 3;

    // ----------------------------------------------------------------
    // Status flag bit positions
    // ----------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ----------------------------------------------------------------
    // Cycle counts
    // ----------------------------------------------------------------
    localparam logic [2:0] CYC_SINGLE      = 3'h1;
    localparam logic [2:0] CYC_REL_JUMP    = 3'h2;
    localparam logic [2:0] CYC_IND_JUMP    = 3'h2;
    localparam logic [2:0] CYC_DIR_JUMP    = 3'h3;
    localparam logic [2:0] CYC_REL_CALL    = 3'h3;
    localparam logic [2:0] CYC_IND_CALL    = 3'h3;
    localparam logic [2:0] CYC_DIR_CALL    = 3'h4;
    localparam logic [2:0] CYC_RETURN      = 3'h4;
    localparam logic [2:0] CYC_BR_TAKEN    = 3'h2;
    localparam logic [2:0] CYC_SKIP_SHORT  = 3'h2;
    localparam logic [2:0] CYC_SKIP_LONG   = 3'h3;

    // ----------------------------------------------------------------
    // Program counter steps
    // ----------------------------------------------------------------
    localparam logic [13:0] STEP_ONE        = 14'h0001;
    localparam logic [13:0] STEP_DIRECT     = 14'h0002;
    localparam logic [13:0] STEP_SKIP_SHORT = 14'h0002;
    localparam logic [13:0] STEP_SKIP_LONG  = 14'h0003;

    // ----------------------------------------------------------------
    // Operations
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        relative_jump, indirect_jump, direct_jump,
        relative_subroutine_call, indirect_subroutine_call, direct_subroutine_call,
        subroutine_exit, interrupt_exit,
        compare_skip_equal, compare_regs, compare_with_carry, compare_immediate,
        skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
        branch_status_bit_set, branch_status_bit_clear,
        branch_equal, branch_not_equal, branch_carry_set, branch_carry_clear,
        branch_same_or_higher, branch_lower, branch_minus, branch_plus,
        branch_signed_ge, branch_signed_lt, branch_half_carry_set,
        branch_half_carry_clear, branch_tflag_set, branch_tflag_clear,
        branch_overflow_set, branch_overflow_clear, branch_interrupts_on
    } op_t;

    typedef enum logic {IDLE, EXEC} state_t;

endpackage

// >>> src/compare_flags.sv
// Subtract-only flag generator for the compare operations
`timescale 1ns/10ps
`default_nettype none

module compare_flags (
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    input  wire logic       carryIn,
    input  wire logic       useCarry,
    input  wire logic       zeroIn,
    output logic      [5:0] flags
);

    logic [7:0] diff;
    logic       a7;
    logic       b7;
    logic       r7;

    // ----------------------------------------------------------------
    // Difference kept internal, never written back
    // ----------------------------------------------------------------
    // subtract for flags
    always_comb begin
        diff = minuend - subtrahend - {7'h00, useCarry & carryIn};
        a7   = minuend[7];
        b7   = subtrahend[7];
        r7   = diff[7];
        flags[branch_skip_pkg::FLAG_C] = (~a7 & b7) | (b7 & r7) | (r7 & ~a7);
        // Carry form keeps zero only while every byte so far was zero
        flags[branch_skip_pkg::FLAG_Z] = (diff == 8'h00) & (~useCarry | zeroIn);
        flags[branch_skip_pkg::FLAG_N] = r7;
        flags[branch_skip_pkg::FLAG_V] = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
        flags[branch_skip_pkg::FLAG_S] = r7 ^ ((a7 & ~b7 & ~r7) | (~a7 & b7 & r7));
        flags[branch_skip_pkg::FLAG_H] = (~minuend[3] & subtrahend[3])
                                       | (subtrahend[3] & diff[3])
                                       | (diff[3] & ~minuend[3]);
    end

endmodule // compare_flags

`default_nettype wire

// >>> src/branch_skip_control_unit.sv
// Control-flow unit: jumps, calls, returns, compares, skips and branches
// Operation
// - Relative jump or call loads program counter with pc plus offset plus one.
// - Relative and indirect jump take 2 cycles; direct jump takes 3.
// - Relative/indirect calls 3 cycles, direct call 4, returns restore pc in 4.
// - Compare-skip-equal skips 1 or 2 words when equal, 1/2/3 cycles, no flags.
// - Compares only update Z, N, V, S, C, H flags; no result register written.
// - Register-bit skips skip when selected bit is clear or set; 1/2/3 cycles.
// - I/O-bit skips test an I/O bit and skip likewise; no flags changed.
// - Status-bit branches pick a flag by operand and branch on set or clear.
// - Branch equal takes branch on Z one; not-equal on Z zero.
// - Carry-set and lower branch on C one; carry-clear and same-or-higher on zero.
// - Minus branches on N one, plus on N zero.
// - Signed greater-or-equal branches when N xor V is 0, less-than when 1.
// - Half-carry branches on H one or zero.
// - T-flag branches on T one or zero.
// - Overflow branches on V one or zero.
// - Interrupts-on branch is taken when the global enable flag is one.
`timescale 1ns/10ps
`default_nettype none

module branch_skip_control_unit (
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic                  start,
    input  wire branch_skip_pkg::op_t  op,
    input  wire logic [13:0]           pc,
    input  wire logic [11:0]           relOffset,
    input  wire logic [13:0]           absTarget,
    input  wire logic [15:0]           zPointer,
    input  wire logic [13:0]           stackTop,
    input  wire logic [7:0]            regD,
    input  wire logic [7:0]            regR,
    input  wire logic [7:0]            ioValue,
    input  wire logic [2:0]            bitSel,
    input  wire logic [7:0]            flagsIn,
    input  wire logic                  nextIsLong,
    output logic                       ready_r,
    output logic                       done_r,
    output logic      [13:0]           pcNext_r,
    output logic      [7:0]            flagsOut_r,
    output logic                       flagsWrite_r,
    output logic                       stackPush_r,
    output logic      [13:0]           pushAddr_r,
    output logic                       stackPop_r
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // sign extension
    function automatic logic [13:0] signExt(input logic [11:0] v, input logic shortForm);
        logic [13:0] r;
        if (shortForm) begin
            r = {{(14 - branch_skip_pkg::BR_W){v[branch_skip_pkg::BR_W - 1]}},
                 v[branch_skip_pkg::BR_W - 1:0]};
        end else begin
            r = {{(14 - branch_skip_pkg::REL_W){v[branch_skip_pkg::REL_W - 1]}}, v};
        end
        return r;
    endfunction

    branch_skip_pkg::state_t state_r;
    logic [2:0]  cnt_r;
    logic        pushPend_r;
    logic        popPend_r;
    logic        flagPend_r;

    logic [13:0] pcPlus1;
    logic [13:0] pcPlus2;
    logic [13:0] relTarget;
    logic [13:0] brTarget;
    logic [13:0] zTarget;
    logic        eqRegs;
    logic        brCond;
    logic        isBranch;
    logic        skipCond;
    logic        isSkip;
    logic [5:0]  cmpFlags;
    logic        take;

    logic [13:0] pc_nxt;
    logic [2:0]  cyc_nxt;
    logic [7:0]  flags_nxt;
    logic        flagWe_nxt;
    logic        push_nxt;
    logic [13:0] pushAddr_nxt;
    logic        pop_nxt;

    compare_flags u_cmp (
        .minuend    (regD),
        .subtrahend (regR),
        .carryIn    (flagsIn[branch_skip_pkg::FLAG_C]),
        .useCarry   (op == branch_skip_pkg::compare_with_carry),
        .zeroIn     (flagsIn[branch_skip_pkg::FLAG_Z]),
        .flags      (cmpFlags)
    );

    // ----------------------------------------------------------------
    // Targets and conditions
    // ----------------------------------------------------------------
    always_comb begin
        pcPlus1 = pc + branch_skip_pkg::STEP_ONE;
        pcPlus2 = pc + branch_skip_pkg::STEP_DIRECT;
        relTarget = pc + signExt(relOffset, 1'b0) + branch_skip_pkg::STEP_ONE;
        brTarget  = pc + signExt(relOffset, 1'b1) + branch_skip_pkg::STEP_ONE;
        zTarget   = zPointer[13:0];
        eqRegs    = (regD == regR);
        isBranch  = 1'b1;
        brCond    = 1'b0;
        unique case (op)
            branch_skip_pkg::branch_status_bit_set:   brCond = flagsIn[bitSel];
            branch_skip_pkg::branch_status_bit_clear: brCond = ~flagsIn[bitSel];
            branch_skip_pkg::branch_equal:     brCond = flagsIn[branch_skip_pkg::FLAG_Z];
            branch_skip_pkg::branch_not_equal: brCond = ~flagsIn[branch_skip_pkg::FLAG_Z];
            branch_skip_pkg::branch_carry_set,
            branch_skip_pkg::branch_lower:     brCond = flagsIn[branch_skip_pkg::FLAG_C];
            branch_skip_pkg::branch_carry_clear,
            branch_skip_pkg::branch_same_or_higher:
                brCond = ~flagsIn[branch_skip_pkg::FLAG_C];
            branch_skip_pkg::branch_minus: brCond = flagsIn[branch_skip_pkg::FLAG_N];
            branch_skip_pkg::branch_plus:  brCond = ~flagsIn[branch_skip_pkg::FLAG_N];
            branch_skip_pkg::branch_signed_ge:
                brCond = ~(flagsIn[branch_skip_pkg::FLAG_N] ^ flagsIn[branch_skip_pkg::FLAG_V]);
            branch_skip_pkg::branch_signed_lt:
                brCond = flagsIn[branch_skip_pkg::FLAG_N] ^ flagsIn[branch_skip_pkg::FLAG_V];
            branch_skip_pkg::branch_half_carry_set:
                brCond = flagsIn[branch_skip_pkg::FLAG_H];
            branch_skip_pkg::branch_half_carry_clear:
                brCond = ~flagsIn[branch_skip_pkg::FLAG_H];
            branch_skip_pkg::branch_tflag_set:   brCond = flagsIn[branch_skip_pkg::FLAG_T];
            branch_skip_pkg::branch_tflag_clear: brCond = ~flagsIn[branch_skip_pkg::FLAG_T];
            branch_skip_pkg::branch_overflow_set:   brCond = flagsIn[branch_skip_pkg::FLAG_V];
            branch_skip_pkg::branch_overflow_clear: brCond = ~flagsIn[branch_skip_pkg::FLAG_V];
            branch_skip_pkg::branch_interrupts_on: brCond = flagsIn[branch_skip_pkg::FLAG_I];
            default: isBranch = 1'b0;
        endcase
        isSkip   = 1'b1;
        skipCond = 1'b0;
        unique case (op)
            branch_skip_pkg::compare_skip_equal: skipCond = eqRegs;
            branch_skip_pkg::skip_reg_bit_clear: skipCond = ~regR[bitSel];
            branch_skip_pkg::skip_reg_bit_set:   skipCond = regR[bitSel];
            branch_skip_pkg::skip_io_bit_clear:  skipCond = ~ioValue[bitSel];
            branch_skip_pkg::skip_io_bit_set:    skipCond = ioValue[bitSel];
            default: isSkip = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Per-operation result
    // ----------------------------------------------------------------
    always_comb begin
        pc_nxt       = pcPlus1;
        cyc_nxt      = branch_skip_pkg::CYC_SINGLE;
        flags_nxt    = flagsIn;
        flagWe_nxt   = 1'b0;
        push_nxt     = 1'b0;
        pushAddr_nxt = pcPlus1;
        pop_nxt      = 1'b0;
        unique case (op)
            branch_skip_pkg::relative_jump: begin
                pc_nxt  = relTarget;
                cyc_nxt = branch_skip_pkg::CYC_REL_JUMP;
            end
            branch_skip_pkg::indirect_jump: begin
                pc_nxt  = zTarget;
                cyc_nxt = branch_skip_pkg::CYC_IND_JUMP;
            end
            branch_skip_pkg::direct_jump: begin
                pc_nxt  = absTarget;
                cyc_nxt = branch_skip_pkg::CYC_DIR_JUMP;
            end
            branch_skip_pkg::relative_subroutine_call: begin
                pc_nxt   = relTarget;
                cyc_nxt  = branch_skip_pkg::CYC_REL_CALL;
                push_nxt = 1'b1;
            end
            branch_skip_pkg::indirect_subroutine_call: begin
                pc_nxt   = zTarget;
                cyc_nxt  = branch_skip_pkg::CYC_IND_CALL;
                push_nxt = 1'b1;
            end
            branch_skip_pkg::direct_subroutine_call: begin
                pc_nxt       = absTarget;
                cyc_nxt      = branch_skip_pkg::CYC_DIR_CALL;
                push_nxt     = 1'b1;
                pushAddr_nxt = pcPlus2;
            end
            branch_skip_pkg::subroutine_exit: begin
                pc_nxt  = stackTop;
                cyc_nxt = branch_skip_pkg::CYC_RETURN;
                pop_nxt = 1'b1;
            end
            branch_skip_pkg::interrupt_exit: begin
                pc_nxt     = stackTop;
                cyc_nxt    = branch_skip_pkg::CYC_RETURN;
                pop_nxt    = 1'b1;
                flags_nxt[branch_skip_pkg::FLAG_I] = 1'b1;
                flagWe_nxt = 1'b1;
            end
            branch_skip_pkg::compare_regs,
            branch_skip_pkg::compare_with_carry,
            branch_skip_pkg::compare_immediate: begin
                flags_nxt[5:0] = cmpFlags;
                flagWe_nxt     = 1'b1;
            end
            default: begin
                if (isBranch && brCond) begin
                    pc_nxt  = brTarget;
                    cyc_nxt = branch_skip_pkg::CYC_BR_TAKEN;
                end else if (isSkip && skipCond) begin
                    pc_nxt  = nextIsLong ? pc + branch_skip_pkg::STEP_SKIP_LONG
                                         : pc + branch_skip_pkg::STEP_SKIP_SHORT;
                    cyc_nxt = nextIsLong ? branch_skip_pkg::CYC_SKIP_LONG
                                         : branch_skip_pkg::CYC_SKIP_SHORT;
                end
            end
        endcase
    end

    assign take = start & ready_r;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // cycle count
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= branch_skip_pkg::IDLE;
            cnt_r   <= 3'h0;
            ready_r <= 1'b1;
            done_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (state_r)
                branch_skip_pkg::IDLE: begin
                    if (take) begin
                        cnt_r <= cyc_nxt - 3'h1;
                        if (cyc_nxt == branch_skip_pkg::CYC_SINGLE) begin
                            done_r <= 1'b1;
                        end else begin
                            ready_r <= 1'b0;
                            state_r <= branch_skip_pkg::EXEC;
                        end
                    end
                end
                branch_skip_pkg::EXEC: begin
                    cnt_r <= cnt_r - 3'h1;
                    if (cnt_r == 3'h1) begin
                        done_r  <= 1'b1;
                        ready_r <= 1'b1;
                        state_r <= branch_skip_pkg::IDLE;
                    end
                end
            endcase
        end
    end

    // Results latch at issue so inputs may change while the unit is busy
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pcNext_r   <= 14'h0000;
            flagsOut_r <= 8'h00;
            pushAddr_r <= 14'h0000;
            pushPend_r <= 1'b0;
            popPend_r  <= 1'b0;
            flagPend_r <= 1'b0;
        end else if (take) begin
            pcNext_r   <= pc_nxt;
            flagsOut_r <= flags_nxt;
            pushAddr_r <= pushAddr_nxt;
            pushPend_r <= push_nxt;
            popPend_r  <= pop_nxt;
            flagPend_r <= flagWe_nxt;
        end
    end

    // Strobes fire together with done so the core sees one commit point
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stackPush_r  <= 1'b0;
            stackPop_r   <= 1'b0;
            flagsWrite_r <= 1'b0;
        end else begin
            stackPush_r  <= 1'b0;
            stackPop_r   <= 1'b0;
            flagsWrite_r <= 1'b0;
            if (take && cyc_nxt == branch_skip_pkg::CYC_SINGLE) begin
                flagsWrite_r <= flagWe_nxt;
            end else if (state_r == branch_skip_pkg::EXEC && cnt_r == 3'h1) begin
                stackPush_r  <= pushPend_r;
                stackPop_r   <= popPend_r;
                flagsWrite_r <= flagPend_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_rel_jump;
        @(posedge clock) disable iff (!rst_b)
        take && op == branch_skip_pkg::relative_jump |->
            ##1 !done_r ##1 done_r && pcNext_r == $past(relTarget, 2);
    endproperty
    a_rel_jump: assert property (p_rel_jump) else $error("relative jump wrong");

    property p_ind_jump;
        @(posedge clock) disable iff (!rst_b)
        take && op == branch_skip_pkg::indirect_jump |->
            ##1 !done_r ##1 done_r && pcNext_r == $past(zTarget, 2);
    endproperty
    a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong");

    property p_dir_jump;
        @(posedge clock) disable iff (!rst_b)
        take && op == branch_skip_pkg::direct_jump |-> ##1 (!done_r)[*2] ##1 done_r;
    endproperty
    a_dir_jump: assert property (p_dir_jump) else $error("direct jump timing");

    property p_dir_call;
        @(posedge clock) disable iff (!rst_b)
        take && op == branch_skip_pkg::direct_subroutine_call |->
            ##4 done_r && stackPush_r && pushAddr_r == $past(pcPlus2, 4);
    endproperty
    a_dir_call: assert property (p_dir_call) else $error("direct call wrong");

    property p_return;
        @(posedge clock) disable iff (!rst_b)
        take && op == branch_skip_pkg::subroutine_exit |->
            ##1 (!done_r)[*3] ##1 done_r && stackPop_r && pcNext_r == $past(stackTop, 4);
    endproperty
    a_return: assert property (p_return) else $error("return wrong");

    property p_compare_skip_equal_long;
        @(posedge clock) disable iff (!rst_b)
        take && op == branch_skip_pkg::compare_skip_equal && eqRegs && nextIsLong |->
            ##3 done_r && !flagsWrite_r && pcNext_r == $past(pc, 3) + 14'h0003;
    endproperty
    a_compare_skip_equal_long: assert property (p_compare_skip_equal_long) else $error("equal skip wrong");

    property p_cmp_zero;
        @(posedge clock) disable iff (!rst_b)
        take && op == branch_skip_pkg::compare_regs |->
            ##1 done_r && flagsWrite_r && flagsOut_r[1] == $past(eqRegs);
    endproperty
    a_cmp_zero: assert property (p_cmp_zero) else $error("compare zero wrong");

    property p_skip_idle;
        @(posedge clock) disable iff (!rst_b)
        take && isSkip && !skipCond |-> ##1 done_r && pcNext_r == $past(pcPlus1);
    endproperty
    a_skip_idle: assert property (p_skip_idle) else $error("skip not taken wrong");

    property p_br_idle;
        @(posedge clock) disable iff (!rst_b)
        take && isBranch && !brCond |-> ##1 done_r && pcNext_r == $past(pcPlus1);
    endproperty
    a_br_idle: assert property (p_br_idle) else $error("branch not taken wrong");

    property p_signed_ge;
        @(posedge clock) disable iff (!rst_b)
        take && op == branch_skip_pkg::branch_signed_ge && !(flagsIn[2] ^ flagsIn[3]) |->
            ##2 done_r && pcNext_r == $past(brTarget, 2);
    endproperty
    a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong");

endmodule // branch_skip_control_unit

`default_nettype wire

// >>> bench/tb_branch_skip_control_unit.sv
// Self-checking bench for the branch and skip control unit
`timescale 1ns/10ps
`default_nettype none
module tb_branch_skip_control_unit;
    logic                 clock = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 start = 1'b0;
    branch_skip_pkg::op_t op = branch_skip_pkg::relative_jump;
    logic [13:0]          pc = 14'h0100, absTarget = 14'h0000, stackTop = 14'h0000;
    logic [11:0]          relOffset = 12'h000;
    logic [15:0]          zPointer = 16'h0000;
    logic [7:0]           regD = 8'h00, regR = 8'h00, ioValue = 8'h00, flagsIn = 8'h00;
    logic [2:0]           bitSel = 3'h0;
    logic                 nextIsLong = 1'b0;
    logic                 ready_r, done_r, flagsWrite_r, stackPush_r, stackPop_r;
    logic [13:0]          pcNext_r, pushAddr_r;
    logic [7:0]           flagsOut_r;
    int                   miscompares = 0, tests_run = 0, cycles = 0;

    branch_skip_control_unit uut (.clock, .rst_b, .start, .op, .pc, .relOffset, .absTarget,
        .zPointer, .stackTop, .regD, .regR, .ioValue, .bitSel, .flagsIn, .nextIsLong,
        .ready_r, .done_r, .pcNext_r, .flagsOut_r, .flagsWrite_r, .stackPush_r,
        .pushAddr_r, .stackPop_r);

    always #2.5 clock = ~clock;

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Launch one operation, count cycles up to done and check the new pc
    task automatic go(input branch_skip_pkg::op_t o, input logic [2:0] c, input logic [13:0] p);
        int n;
        @(negedge clock);
        op = o;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        n = 1;
        while (done_r !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        chk("cycles", {13'h0, c}, n[15:0]);
        chk("pcNext", {2'h0, p}, {2'h0, pcNext_r});
    endtask

    task automatic cmp(input branch_skip_pkg::op_t o, input logic [7:0] d, input logic [7:0] r,
                       input logic [7:0] f, input logic [5:0] e);
        regD = d;
        regR = r;
        flagsIn = f;
        go(o, 3'h1, pc + 14'h1);
        chk("flags", {10'h0, e}, {10'h0, flagsOut_r[5:0]});
        chk("flagsWrite", 16'h1, {15'h0, flagsWrite_r});
    endtask

    task automatic t_jumps();
        relOffset = 12'hFFE;
        go(branch_skip_pkg::relative_jump, 3'h2, 14'h00FF);
        zPointer = 16'hC123;
        go(branch_skip_pkg::indirect_jump, 3'h2, 14'h0123);
        absTarget = 14'h2ABC;
        go(branch_skip_pkg::direct_jump, 3'h3, 14'h2ABC);
        stackTop = 14'h1357;
        go(branch_skip_pkg::subroutine_exit, 3'h4, 14'h1357);
        chk("pop", 16'h1, {15'h0, stackPop_r});
        go(branch_skip_pkg::interrupt_exit, 3'h4, 14'h1357);
        chk("iFlag", 16'h1, {15'h0, flagsOut_r[7]});
        chk("iWrite", 16'h1, {15'h0, flagsWrite_r});
    endtask

    task automatic t_calls();
        pc = 14'h0200;
        relOffset = 12'h7FF;
        go(branch_skip_pkg::relative_subroutine_call, 3'h3, 14'h0A00);
        chk("push", 16'h1, {15'h0, stackPush_r});
        chk("relPushAddr", 16'h0201, {2'h0, pushAddr_r});
        zPointer = 16'h0040;
        go(branch_skip_pkg::indirect_subroutine_call, 3'h3, 14'h0040);
        absTarget = 14'h1000;
        go(branch_skip_pkg::direct_subroutine_call, 3'h4, 14'h1000);
        chk("pushAddr", 16'h0202, {2'h0, pushAddr_r});
    endtask

    task automatic t_compares();
        cmp(branch_skip_pkg::compare_regs, 8'h10, 8'h20, 8'h00, 6'b010101);
        cmp(branch_skip_pkg::compare_regs, 8'h80, 8'h01, 8'h00, 6'b111000);
        cmp(branch_skip_pkg::compare_with_carry, 8'h21, 8'h20, 8'h03, 6'b000010);
        cmp(branch_skip_pkg::compare_with_carry, 8'h21, 8'h20, 8'h01, 6'b000000);
        cmp(branch_skip_pkg::compare_immediate, 8'h05, 8'h05, 8'h00, 6'b000010);
        nextIsLong = 1'b1;
        go(branch_skip_pkg::compare_skip_equal, 3'h3, pc + 14'h3);
        chk("noFlags", 16'h0, {15'h0, flagsWrite_r});
        regR = 8'h06;
        go(branch_skip_pkg::compare_skip_equal, 3'h1, pc + 14'h1);
    endtask

    task automatic t_skips();
        logic [2:0] c;
        bitSel = 3'h5;
        for (int i = 0; i < 16; i++) begin
            regR = i[2] ? 8'h20 : 8'hDF;
            ioValue = regR;
            nextIsLong = i[3];
            c = (i[2] != i[0]) ? 3'h1 : (i[3] ? 3'h3 : 3'h2);
            go(branch_skip_pkg::op_t'(12 + i % 4), c, pc + {11'h0, c});
            chk("noFlags", 16'h0, {15'h0, flagsWrite_r});
        end
    endtask

    task automatic t_branches();
        logic [7:0] pat [3] = '{8'h00, 8'hFF, 8'h08};
        logic       v;
        logic [13:0] p;
        for (int k = 0; k < 19; k++) begin
            for (int j = 0; j < 3; j++) begin
                flagsIn = pat[j];
                bitSel = 3'(k + j);
                relOffset = j[0] ? 12'h03F : 12'hFC0;
                case (k)
                    0, 1: v = flagsIn[bitSel];
                    2, 3: v = flagsIn[1];
                    4, 5: v = flagsIn[0];
                    6, 7: v = !flagsIn[0];
                    8, 9: v = flagsIn[2];
                    10, 11: v = !(flagsIn[2] ^ flagsIn[3]);
                    12, 13: v = flagsIn[5];
                    14, 15: v = flagsIn[6];
                    16, 17: v = flagsIn[3];
                    default: v = flagsIn[7];
                endcase
                v = v ^ k[0];
                p = pc + {{7{relOffset[6]}}, relOffset[6:0]} + 14'h1;
                go(branch_skip_pkg::op_t'(16 + k), v ? 3'h2 : 3'h1, v ? p : pc + 14'h1);
            end
        end
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk("doneInReset", 16'h0, {15'h0, done_r});
        rst_b = 1'b1;
        chk("ready", 16'h1, {15'h0, ready_r});
        t_jumps();
        t_calls();
        t_compares();
        t_skips();
        t_branches();
        wrap_up();
    end
endmodule // tb_branch_skip_control_unit
`default_nettype wire
